// ---- core/vcp_pkg.sv ----
package vcp_pkg;
  // processor port map, write side
  localparam logic [4:0] VCP_ADDR_BIT_COUNT = 5'h08;
  localparam logic [4:0] VCP_ADDR_NORM_COUNT = 5'h09;
  localparam logic [4:0] VCP_ADDR_RSVD_A = 5'h15;
  localparam logic [4:0] VCP_ADDR_RSVD_B = 5'h16;
  localparam logic [4:0] VCP_ADDR_NORM_ENABLE = 5'h17;
  // read side status byte
  localparam logic [4:0] VCP_ADDR_STATUS = 5'h00;
  localparam int VCP_STAT_DONE = 0;
  localparam int VCP_STAT_PHASE = 1;
  // reset values
  localparam logic [7:0] VCP_COUNT_RESET = 8'h00;
  localparam logic [6:0] VCP_WIN_RESET = 7'h00;
  localparam logic [1:0] VCP_PHASE_RESET = 2'h0;
  // code: constraint length seven, newest bit in bit 6
  localparam int VCP_SOFT_W = 3;
  localparam int VCP_WIN_W = 7;
  localparam logic [6:0] VCP_GEN_A = 7'h79;
  localparam logic [6:0] VCP_GEN_B = 7'h5b;
  localparam logic [6:0] VCP_GEN_C = 7'h75;
  // result pulse length in decoder output clock periods
  localparam logic [1:0] VCP_FLAG_PERIODS = 2'h2;

  typedef enum logic [1:0] {
    VCP_MON_IDLE = 2'b01,
    VCP_MON_RUN = 2'b10
  } vcp_mon_state_type;

  // one code tap set applied to a window of bits
  function automatic logic vcp_parity(input logic [6:0] win, input logic [6:0] gen);
    return ^(win & gen);
  endfunction
endpackage

// ---- core/vcp_sync_monitor.sv ----
`timescale 1ns/10ps
module vcp_sync_monitor
  import vcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bit_stb_i,
  input wire logic err_stb_i,
  input wire logic out_edge_i,
  input wire logic restart_i,
  input wire logic [7:0] bit_count_i,
  input wire logic [7:0] norm_count_i,
  output logic fail_o,
  output logic pass_o,
  output logic done_o
);
  vcp_mon_state_type state_reg;
  logic [7:0] bits_reg;
  logic [8:0] errs_reg;
  logic [1:0] cnt_reg;
  logic fail_reg;
  logic pass_reg;
  logic done_reg;

  // window ends on the last bit; a count of zero gives 256 bits
  wire last_bit = (state_reg == VCP_MON_RUN) && bit_stb_i
                  && (8'(bits_reg + 8'h01) == bit_count_i);
  wire [8:0] errs_now = 9'(errs_reg + {8'h00, err_stb_i});
  wire is_fail = errs_now > {1'b0, norm_count_i};

  // window counting, restarts after each verdict
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= VCP_MON_IDLE;
      bits_reg <= 8'h00;
      errs_reg <= 9'h000;
    end else if (restart_i || last_bit) begin
      state_reg <= VCP_MON_RUN;
      bits_reg <= 8'h00;
      errs_reg <= 9'h000;
    end else begin
      case (state_reg)
        VCP_MON_RUN: begin
          if (bit_stb_i) begin
            bits_reg <= 8'(bits_reg + 8'h01);
            errs_reg <= errs_now;
          end
        end
        default: state_reg <= VCP_MON_IDLE;
      endcase
    end
  end

  // result pulses stretched over two output clock periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_reg <= 1'b0;
      pass_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (last_bit) begin
      fail_reg <= is_fail;
      pass_reg <= !is_fail;
      cnt_reg <= VCP_FLAG_PERIODS;
    end else if (out_edge_i && cnt_reg != 2'h0) begin
      cnt_reg <= 2'(cnt_reg - 2'h1);
      if (cnt_reg == 2'h1) begin
        fail_reg <= 1'b0;
        pass_reg <= 1'b0;
      end
    end
  end

  // done is sticky; a verdict in the restart cycle still wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else if (last_bit) begin
      done_reg <= 1'b1;
    end else if (restart_i) begin
      done_reg <= 1'b0;
    end
  end

  assign fail_o = fail_reg;
  assign pass_o = pass_reg;
  assign done_o = done_reg;

  a_pulse_start_count: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fail_reg | pass_reg) |-> cnt_reg == 2'h2)
    else $error("result pulse started without a two period count");
  a_pulse_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (out_edge_i && cnt_reg == 2'h1 && !last_bit) |=> !fail_reg && !pass_reg)
    else $error("result pulse outlived two output periods");
  a_done_on_verdict: assert property (@(posedge clk_i) disable iff (rst_i)
    last_bit |=> done_reg && (fail_reg ^ pass_reg))
    else $error("verdict did not raise done and one result");
endmodule

// ---- core/vcp_codec.sv ----
`timescale 1ns/10ps
// What this block does
// - write to enable register loads staged counts and restarts the monitor
// - writes to unused addresses are ignored, no storage or effect
// - encoder takes bits on input clock, emits symbols on output clock
// - three coded outputs plus a marker for the first bit of a set
// - high encoder reset clears all encoder state
// - decoder takes three 3-bit soft symbols on its input clock
// - low first-select makes the current input the first symbol
// - erased symbols carry no weight and raise no error
// - high decoder reset clears all decoder state
// - sync change input steps to the next phase hypothesis
// - separate monitor fail and monitor pass outputs
// - decoded bits and clock out follow the decoder output clock
// - per-symbol channel errors from re-encoded bits against hard decisions
// - error timing output aligned with the channel error outputs
// - 8-bit two-way data bus and 5-bit address bus
// - write, read strobes and chip select are active low
// - each monitor result pulses for two output clock periods
// - each channel error lasts one output clock period
// - done output rises when the monitor test finishes
module vcp_codec
  import vcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic encoder_serial_input_i,
  input wire logic encoder_input_clock_i,
  input wire logic encoder_output_clock_i,
  input wire logic encoder_master_reset_i,
  output logic encoder_symbol_clock_out_o,
  output logic first_symbol_marker_o,
  output logic first_channel_symbol_o,
  output logic second_channel_symbol_o,
  output logic third_channel_symbol_o,
  input wire logic [VCP_SOFT_W-1:0] received_symbol_a_i,
  input wire logic [VCP_SOFT_W-1:0] received_symbol_b_i,
  input wire logic [VCP_SOFT_W-1:0] received_symbol_c_i,
  input wire logic first_input_select_n_i,
  input wire logic erase_symbol_a_i,
  input wire logic erase_symbol_b_i,
  input wire logic erase_symbol_c_i,
  input wire logic decoder_input_clock_i,
  input wire logic decoder_output_clock_i,
  input wire logic decoder_master_reset_i,
  input wire logic phase_step_request_i,
  input wire logic code_rate_third_i,
  output logic decoder_clock_out_o,
  output logic monitor_fail_pulse_o,
  output logic monitor_pass_pulse_o,
  output logic decoded_bit_out_o,
  output logic channel_error_a_o,
  output logic channel_error_b_o,
  output logic channel_error_c_or_erase_b_o,
  output logic error_timing_out_o,
  output logic error_rate_test_done_o,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic [4:0] addr_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic cs_n_i
);
  // pin clocks are sampled; their rising edges become enables
  logic enc_in_prev_reg;
  logic enc_out_prev_reg;
  logic dec_in_prev_reg;
  logic dec_out_prev_reg;
  logic step_prev_reg;
  logic wr_prev_reg;

  wire enc_rst = !rst_n_i || encoder_master_reset_i;
  wire dec_rst = !rst_n_i || decoder_master_reset_i;
  wire enc_in_edge = encoder_input_clock_i && !enc_in_prev_reg;
  wire enc_out_edge = encoder_output_clock_i && !enc_out_prev_reg;
  wire dec_in_edge = decoder_input_clock_i && !dec_in_prev_reg;
  wire dec_out_edge = decoder_output_clock_i && !dec_out_prev_reg;
  wire step_edge = phase_step_request_i && !step_prev_reg;
  wire wr_rise = wr_n_i && !wr_prev_reg;

  // edge detect history, strobe idles high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enc_in_prev_reg <= 1'b0;
      enc_out_prev_reg <= 1'b0;
      dec_in_prev_reg <= 1'b0;
      dec_out_prev_reg <= 1'b0;
      step_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
    end else begin
      enc_in_prev_reg <= encoder_input_clock_i;
      enc_out_prev_reg <= encoder_output_clock_i;
      dec_in_prev_reg <= decoder_input_clock_i;
      dec_out_prev_reg <= decoder_output_clock_i;
      step_prev_reg <= phase_step_request_i;
      wr_prev_reg <= wr_n_i;
    end
  end

  // ---------------- processor port ----------------
  logic [4:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic wr_armed_reg;
  logic [7:0] bit_stage_reg;
  logic [7:0] norm_stage_reg;
  logic [7:0] bit_active_reg;
  logic [7:0] norm_active_reg;
  logic restart_reg;
  logic [7:0] data_reg;
  logic data_oe_reg;
  logic [1:0] phase_reg;
  logic mon_done;

  wire wr_cycle = !cs_n_i && !wr_n_i;
  wire commit = wr_rise && wr_armed_reg;
  wire hit_enable = commit && (wr_addr_reg == VCP_ADDR_NORM_ENABLE);
  wire [7:0] status_byte = {5'h00, phase_reg, mon_done};
  wire [7:0] read_next = (addr_i == VCP_ADDR_STATUS) ? status_byte : 8'h00;

  // latch address and data during the strobe, act at its release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 8'h00;
      wr_armed_reg <= 1'b0;
    end else if (wr_cycle) begin
      wr_addr_reg <= addr_i;
      wr_data_reg <= data_i;
      wr_armed_reg <= 1'b1;
    end else if (wr_rise) begin
      wr_armed_reg <= 1'b0;
    end
  end

  // staged counts only reach the monitor through the enable write;
  // reserved and unused addresses fall through with no storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bit_stage_reg <= VCP_COUNT_RESET;
      norm_stage_reg <= VCP_COUNT_RESET;
      bit_active_reg <= VCP_COUNT_RESET;
      norm_active_reg <= VCP_COUNT_RESET;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= hit_enable;
      if (commit && wr_addr_reg == VCP_ADDR_BIT_COUNT) begin
        bit_stage_reg <= wr_data_reg;
      end
      if (commit && wr_addr_reg == VCP_ADDR_NORM_COUNT) begin
        norm_stage_reg <= wr_data_reg;
      end
      if (hit_enable) begin
        bit_active_reg <= bit_stage_reg;
        norm_active_reg <= norm_stage_reg;
      end
    end
  end

  // read data and enable registered, one cycle behind the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_reg <= 8'h00;
      data_oe_reg <= 1'b0;
    end else begin
      data_reg <= read_next;
      data_oe_reg <= !cs_n_i && !rd_n_i;
    end
  end

  // ---------------- encoder ----------------
  logic [VCP_WIN_W-1:0] enc_win_reg;
  logic enc_fresh_reg;
  logic enc_clk_reg;
  logic enc_mark_reg;
  logic [2:0] enc_sym_reg;

  // shift in on the input clock, sample taps on the output clock
  always_ff @(posedge clk_i) begin
    if (enc_rst) begin
      enc_win_reg <= VCP_WIN_RESET;
      enc_fresh_reg <= 1'b0;
      enc_clk_reg <= 1'b0;
      enc_mark_reg <= 1'b0;
      enc_sym_reg <= 3'h0;
    end else begin
      enc_clk_reg <= encoder_output_clock_i;
      if (enc_in_edge) begin
        enc_win_reg <= {encoder_serial_input_i, enc_win_reg[6:1]};
      end
      if (enc_out_edge) begin
        enc_sym_reg[0] <= vcp_parity(enc_win_reg, VCP_GEN_A);
        enc_sym_reg[1] <= vcp_parity(enc_win_reg, VCP_GEN_B);
        enc_sym_reg[2] <= vcp_parity(enc_win_reg, VCP_GEN_C);
        enc_mark_reg <= enc_fresh_reg;
      end
      // a new bit landing on the output edge still marks the next set
      if (enc_in_edge) begin
        enc_fresh_reg <= 1'b1;
      end else if (enc_out_edge) begin
        enc_fresh_reg <= 1'b0;
      end
    end
  end

  // ---------------- decoder ----------------
  logic [VCP_SOFT_W-1:0] sym_a_reg;
  logic [VCP_SOFT_W-1:0] sym_b_reg;
  logic [VCP_SOFT_W-1:0] sym_c_reg;
  logic [2:0] era_reg;
  logic dec_ready_reg;
  logic [5:0] dec_hist_reg;
  logic dec_clk_reg;
  logic dec_bit_reg;
  logic [2:0] err_reg;
  logic etim_reg;

  // phase hypothesis: bit 0 swaps the first two symbols, bit 1 inverts
  wire ha = (phase_reg[0] ? sym_b_reg[2] : sym_a_reg[2]) ^ phase_reg[1];
  wire hb = (phase_reg[0] ? sym_a_reg[2] : sym_b_reg[2]) ^ phase_reg[1];
  wire hc = sym_c_reg[2] ^ phase_reg[1];
  wire ea = phase_reg[0] ? era_reg[1] : era_reg[0];
  wire eb = phase_reg[0] ? era_reg[0] : era_reg[1];
  wire ec = era_reg[2] || !code_rate_third_i;
  // decision comes from the first unerased of symbols a and b, zero if both are erased
  wire dec_bit = !ea ? ha ^ vcp_parity({1'b0, dec_hist_reg}, VCP_GEN_A) :
                 !eb ? hb ^ vcp_parity({1'b0, dec_hist_reg}, VCP_GEN_B) : 1'b0;
  wire [6:0] re_win = {dec_bit, dec_hist_reg};
  wire err_a = !ea && (vcp_parity(re_win, VCP_GEN_A) != ha);
  wire err_b = !eb && (vcp_parity(re_win, VCP_GEN_B) != hb);
  wire err_c = !ec && (vcp_parity(re_win, VCP_GEN_C) != hc);
  wire any_era = code_rate_third_i ? |era_reg : era_reg[0];
  wire dec_step = dec_out_edge && dec_ready_reg;

  // symbol capture: a low select loads all three slots, a high one
  // loads the serial second symbol from the first pin
  always_ff @(posedge clk_i) begin
    if (dec_rst) begin
      sym_a_reg <= 3'h0;
      sym_b_reg <= 3'h0;
      sym_c_reg <= 3'h0;
      era_reg <= 3'h0;
      dec_ready_reg <= 1'b0;
    end else if (dec_in_edge) begin
      dec_ready_reg <= 1'b1;
      if (!first_input_select_n_i) begin
        sym_a_reg <= received_symbol_a_i;
        sym_b_reg <= received_symbol_b_i;
        sym_c_reg <= received_symbol_c_i;
        era_reg <= {erase_symbol_c_i, erase_symbol_b_i, erase_symbol_a_i};
      end else begin
        sym_b_reg <= received_symbol_a_i;
        era_reg[1] <= erase_symbol_a_i;
      end
    end else if (dec_step) begin
      dec_ready_reg <= 1'b0;
    end
  end

  // phase hypothesis advances once per sync change request
  always_ff @(posedge clk_i) begin
    if (dec_rst) begin
      phase_reg <= VCP_PHASE_RESET;
    end else if (step_edge) begin
      phase_reg <= 2'(phase_reg + 2'h1);
    end
  end

  // outputs change only on output clock edges, so each error holds
  // exactly one period; an edge with no symbol pair clears them
  always_ff @(posedge clk_i) begin
    if (dec_rst) begin
      dec_hist_reg <= 6'h00;
      dec_clk_reg <= 1'b0;
      dec_bit_reg <= 1'b0;
      err_reg <= 3'h0;
      etim_reg <= 1'b0;
    end else begin
      dec_clk_reg <= decoder_output_clock_i;
      if (dec_step) begin
        dec_hist_reg <= re_win[6:1];
        dec_bit_reg <= dec_bit;
        // third slot is the shared pin: error c, or erase b at rate one half
        err_reg <= {code_rate_third_i ? err_c : eb, err_b, err_a};
        etim_reg <= any_era;
      end else if (dec_out_edge) begin
        err_reg <= 3'h0;
        etim_reg <= 1'b0;
      end
    end
  end

  vcp_sync_monitor u_monitor (
    .clk_i(clk_i),
    .rst_i(dec_rst),
    .bit_stb_i(dec_step),
    .err_stb_i(err_a || err_b || err_c),
    .out_edge_i(dec_out_edge),
    .restart_i(restart_reg),
    .bit_count_i(bit_active_reg),
    .norm_count_i(norm_active_reg),
    .fail_o(monitor_fail_pulse_o),
    .pass_o(monitor_pass_pulse_o),
    .done_o(mon_done)
  );

  // output pins, all registered
  assign encoder_symbol_clock_out_o = enc_clk_reg;
  assign first_symbol_marker_o = enc_mark_reg;
  assign first_channel_symbol_o = enc_sym_reg[0];
  assign second_channel_symbol_o = enc_sym_reg[1];
  assign third_channel_symbol_o = enc_sym_reg[2];
  assign decoder_clock_out_o = dec_clk_reg;
  assign decoded_bit_out_o = dec_bit_reg;
  assign channel_error_a_o = err_reg[0];
  assign channel_error_b_o = err_reg[1];
  assign channel_error_c_or_erase_b_o = err_reg[2];
  assign error_timing_out_o = etim_reg;
  assign error_rate_test_done_o = mon_done;
  assign data_o = data_reg;
  assign data_oe_o = data_oe_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_strobe_held;
    !cs_n_i && !wr_n_i;
  endsequence
  sequence s_strobe_released;
    wr_n_i;
  endsequence

  a_write_commit: assert property (
    s_strobe_held ##1 s_strobe_released |-> commit)
    else $error("write strobe release did not commit");
  a_norm_apply: assert property (
    hit_enable |=> bit_active_reg == $past(bit_stage_reg) && restart_reg)
    else $error("enable write did not apply counts and restart");
  a_unused_inert: assert property (
    commit && wr_addr_reg == 5'h0a |=> $stable(bit_stage_reg) && $stable(norm_stage_reg))
    else $error("unused address changed state");
  a_enc_shift: assert property (
    enc_in_edge && !encoder_master_reset_i |=> enc_win_reg[6] == $past(encoder_serial_input_i))
    else $error("encoder did not take the input bit");
  a_enc_marker: assert property (
    enc_out_edge && enc_fresh_reg && !encoder_master_reset_i |=> first_symbol_marker_o)
    else $error("marker missing on a new symbol set");
  a_enc_reset: assert property (
    encoder_master_reset_i |=> enc_win_reg == 7'h00 && !first_symbol_marker_o)
    else $error("encoder reset left state");
  a_dec_reset: assert property (
    decoder_master_reset_i |=> !dec_ready_reg && !channel_error_a_o && phase_reg == 2'h0)
    else $error("decoder reset left state");
  a_erase_quiet: assert property (
    dec_step && eb && !decoder_master_reset_i |=> !channel_error_b_o)
    else $error("erased symbol raised an error");
  a_error_period: assert property (
    channel_error_b_o && !dec_out_edge && !decoder_master_reset_i |=> channel_error_b_o)
    else $error("channel error dropped inside its period");
  a_phase_step: assert property (
    step_edge && !decoder_master_reset_i |=> phase_reg == 2'($past(phase_reg) + 2'h1))
    else $error("phase did not step");
  a_first_select: assert property (
    dec_in_edge && !first_input_select_n_i && !decoder_master_reset_i
    |=> sym_a_reg == $past(received_symbol_a_i))
    else $error("first symbol not captured");
endmodule

// ---- verif/vcp_far_model.sv ----
`timescale 1ns/10ps
// datapath side: clock lines and erasure flags for the codec
module vcp_far_model (
  input wire logic clk_i,
  output logic enc_in_clk_o,
  output logic enc_out_clk_o,
  output logic dec_in_clk_o,
  output logic dec_out_clk_o,
  output logic [2:0] erase_o
);
  logic [3:0] clks_reg;

  // clocks stand low outside requested pulses
  assign enc_in_clk_o = clks_reg[0];
  assign enc_out_clk_o = clks_reg[1];
  assign dec_in_clk_o = clks_reg[2];
  assign dec_out_clk_o = clks_reg[3];

  // erasures tied low unless a test asks for them
  initial begin
    clks_reg = 4'h0;
    erase_o = 3'h0;
  end

  // two clk high, two low: the codec sees every level twice
  task automatic pulse(input int idx);
    @(posedge clk_i);
    clks_reg[idx] <= 1'b1;
    repeat (2) @(posedge clk_i);
    clks_reg[idx] <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic set_erase(input logic [2:0] e);
    @(posedge clk_i);
    erase_o <= e;
  endtask
endmodule

// ---- verif/vcp_codec_tb.sv ----
`timescale 1ns/10ps
module vcp_codec_tb;
  import vcp_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, enc_din = 1'b0, enc_rst = 1'b0, dec_rst = 1'b0;
  logic sel_n = 1'b1, phase_req = 1'b0, wr_n = 1'b1, rd_n = 1'b1, cs_n = 1'b1, rate3 = 1'b0;
  logic [2:0] sym_a = 3'h0, sym_b = 3'h0, sym_c = 3'h0;
  logic [4:0] addr = 5'h00;
  logic [7:0] host_dq = 8'h00, data_o, rd_val;
  logic [6:0] win = 7'h00;
  logic data_oe_o, seen_pass, seen_fail, eic, eoc, dic, doc;
  logic sclk, mark, s0, s1, s2, dclk, fail, pass, dbit, ea, eb, ec, etim, done;
  logic [2:0] era;
  wire [7:0] bus = data_oe_o ? data_o : host_dq;
  int num_errors = 0, total_checks = 0;
  int sclk_n = 0, dclk_n = 0;
  logic sclk_q = 1'b0, dclk_q = 1'b0;

  always #50 clk_i = ~clk_i;

  vcp_far_model far_u (.clk_i(clk_i), .enc_in_clk_o(eic), .enc_out_clk_o(eoc),
    .dec_in_clk_o(dic), .dec_out_clk_o(doc), .erase_o(era));

  vcp_codec dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .encoder_serial_input_i(enc_din),
    .encoder_input_clock_i(eic), .encoder_output_clock_i(eoc),
    .encoder_master_reset_i(enc_rst), .encoder_symbol_clock_out_o(sclk),
    .first_symbol_marker_o(mark), .first_channel_symbol_o(s0), .second_channel_symbol_o(s1),
    .third_channel_symbol_o(s2), .received_symbol_a_i(sym_a), .received_symbol_b_i(sym_b),
    .received_symbol_c_i(sym_c), .first_input_select_n_i(sel_n), .erase_symbol_a_i(era[0]),
    .erase_symbol_b_i(era[1]), .erase_symbol_c_i(era[2]), .decoder_input_clock_i(dic),
    .decoder_output_clock_i(doc), .decoder_master_reset_i(dec_rst),
    .phase_step_request_i(phase_req), .code_rate_third_i(rate3), .decoder_clock_out_o(dclk),
    .monitor_fail_pulse_o(fail), .monitor_pass_pulse_o(pass), .decoded_bit_out_o(dbit),
    .channel_error_a_o(ea), .channel_error_b_o(eb), .channel_error_c_or_erase_b_o(ec),
    .error_timing_out_o(etim), .error_rate_test_done_o(done), .data_i(bus),
    .data_o(data_o), .data_oe_o(data_oe_o), .addr_i(addr), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .cs_n_i(cs_n));

  // result pulses are short, so latch them as they go by; count clock copies
  always @(posedge clk_i) begin
    if (pass === 1'b1) seen_pass <= 1'b1;
    if (fail === 1'b1) seen_fail <= 1'b1;
    sclk_q <= sclk;
    dclk_q <= dclk;
    if (sclk === 1'b1 && sclk_q === 1'b0) sclk_n <= sclk_n + 1;
    if (dclk === 1'b1 && dclk_q === 1'b0) dclk_n <= dclk_n + 1;
  end

  function automatic logic enc_sym(input logic [6:0] w, input logic [6:0] g);
    return ^(w & g);
  endfunction

  function automatic logic [7:0] exp_status(input logic d, input logic [1:0] ph);
    return {5'h00, ph, d};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // strobes and chip select together, both active low
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    addr <= a;
    host_dq <= d;
    @(posedge clk_i);
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    @(posedge clk_i);
    host_dq <= ~d; // released lines must not keep the old value
    repeat (2) @(posedge clk_i);
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    repeat (2) @(posedge clk_i);
    #1;
    d = bus;
    check("read drive", 8'(data_oe_o), 8'h01);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  // one decoded bit: parallel capture, then an output clock
  task automatic dec_bit(input logic [2:0] e);
    sym_a <= 3'($urandom);
    sym_b <= 3'($urandom);
    sym_c <= 3'($urandom);
    sel_n <= 1'b0;
    far_u.set_erase(e);
    far_u.pulse(2);
    far_u.pulse(3);
  endtask

  initial begin
    #(3000 * 100);
    num_errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'h172b));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check("marker after reset", 8'(mark), 8'h00);
    // encoder: random bits, each followed by a symbol output
    for (int i = 0; i < 8; i++) begin
      enc_din <= 1'($urandom);
      @(posedge clk_i);
      win = {enc_din, win[6:1]};
      far_u.pulse(0);
      far_u.pulse(1);
      check("enc symbols", {5'h00, s2, s1, s0}, {5'h00, enc_sym(win, VCP_GEN_C),
        enc_sym(win, VCP_GEN_B), enc_sym(win, VCP_GEN_A)});
      check("enc marker", 8'(mark), 8'h01);
    end
    far_u.pulse(1);
    check("marker repeat", 8'(mark), 8'h00);
    @(posedge clk_i);
    enc_rst <= 1'b1;
    repeat (2) @(posedge clk_i);
    enc_rst <= 1'b0;
    @(posedge clk_i);
    check("enc reset", {5'h00, s2, s1, s0}, 8'h00);
    // decoder erasures and error timing, rate one half
    for (int i = 0; i < 4; i++) begin
      dec_bit(3'(i));
      check("timing out", 8'(etim), 8'(i[0]));
      check("erase b out", 8'(ec), 8'(i[1]));
    end
    check("erased errors", {6'h00, ea, eb}, 8'h00);
    // rate one third: erasure of c shows on timing and mutes error c
    rate3 <= 1'b1;
    dec_bit(3'h4);
    check("timing or", 8'(etim), 8'h01);
    check("erased c", 8'(ec), 8'h00);
    rate3 <= 1'b0;
    @(posedge clk_i);
    dec_rst <= 1'b1;
    repeat (2) @(posedge clk_i);
    dec_rst <= 1'b0;
    @(posedge clk_i);
    check("dec reset", {6'h00, etim, ec}, 8'h00);
    far_u.set_erase(3'h0);
    // phase step then monitor: two-bit window, generous threshold
    @(posedge clk_i);
    phase_req <= 1'b1;
    repeat (2) @(posedge clk_i);
    phase_req <= 1'b0;
    bus_wr(VCP_ADDR_RSVD_A, 8'h00);
    bus_wr(VCP_ADDR_RSVD_B, 8'h00);
    bus_wr(VCP_ADDR_BIT_COUNT, 8'h02);
    bus_wr(VCP_ADDR_NORM_COUNT, 8'hff);
    bus_wr(VCP_ADDR_NORM_ENABLE, 8'($urandom));
    seen_pass = 1'b0;
    seen_fail = 1'b0;
    repeat (4) dec_bit(3'h0);
    check("pass pulse", {6'h00, seen_fail, seen_pass}, 8'h01);
    check("done pin", 8'(done), 8'h01);
    bus_rd(VCP_ADDR_STATUS, rd_val);
    check("status", rd_val, exp_status(1'b1, 2'h1));
    // unused addresses take random data and change nothing
    for (int k = 0; k < 7; k++) begin
      bus_wr(5'(k < 4 ? 5'h0a + k : (k == 4 ? 5'h10 : 5'h0e + k)), 8'($urandom));
    end
    bus_rd(VCP_ADDR_STATUS, rd_val);
    check("unused writes", rd_val, exp_status(1'b1, 2'h1));
    bus_rd(VCP_ADDR_RSVD_A, rd_val);
    check("unmapped read", rd_val, 8'h00);
    bus_wr(VCP_ADDR_NORM_ENABLE, 8'h00);
    check("restart clears", 8'(done), 8'h00);
    // serial pair after decoder reset: hard one then hard zero errs on
    // the second symbol; a one-bit window with zero threshold must fail
    dec_rst <= 1'b1;
    @(posedge clk_i);
    dec_rst <= 1'b0;
    bus_wr(VCP_ADDR_BIT_COUNT, 8'h01);
    bus_wr(VCP_ADDR_NORM_COUNT, 8'h00);
    bus_wr(VCP_ADDR_NORM_ENABLE, 8'($urandom));
    seen_pass = 1'b0;
    seen_fail = 1'b0;
    sym_a <= 3'h4;
    sel_n <= 1'b0;
    far_u.pulse(2);
    sym_a <= 3'h0;
    sel_n <= 1'b1;
    far_u.pulse(2);
    far_u.pulse(3);
    check("serial errors", {6'h00, eb, ea}, 8'h02);
    check("serial bit", 8'(dbit), 8'h01);
    check("fail standing", 8'(fail), 8'h01);
    repeat (2) far_u.pulse(3);
    check("errors one period", {6'h00, eb, ea}, 8'h00);
    check("fail pulse", {5'h00, seen_fail, seen_pass, fail}, 8'h04);
    check("symbol clocks", 8'(sclk_n), 8'h09);
    check("decoder clocks", 8'(dclk_n), 8'h0c);
    conclude();
  end
endmodule
